// File: pkg/abs_rx_pkg.sv
// Constants, types and state layout of the absolute encoder data receiver
// Notes on behaviour
// - Input is incremental pulses or absolute data
// - Request output starts the amplifier's transfer
// - Count serial once, then initial pulses
// - Afterwards track position by quadrature counting
// - 9600 baud, start, 7 data, even parity, stop
// - First frame character is header P
// - Short frame: header, sign, 5 digits, CR
// - Long frame adds dot and 6 digits
// - Rotation count limited to plus/minus 65535
// - Frame format follows configured amplifier type
// - Linear direction selectable, matches amplifier setting
// - Motion may start without origin search
// - Circular mode uses initial pulses only
package abs_rx_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ      = 100_000_000;
  localparam int BAUD_BPS    = 9_600;
  localparam int BIT_CYCLES  = CLK_HZ / BAUD_BPS;
  localparam int TIMER_W     = 14;

  // ----------------------------------------------------------------
  // Character codes and frame positions
  // ----------------------------------------------------------------
  localparam logic [6:0] CHAR_HEADER = 7'h50;
  localparam logic [6:0] CHAR_PLUS   = 7'h2B;
  localparam logic [6:0] CHAR_MINUS  = 7'h2D;
  localparam logic [6:0] CHAR_DOT    = 7'h2E;
  localparam logic [6:0] CHAR_CR     = 7'h0D;
  localparam logic [6:0] CHAR_ZERO   = 7'h30;
  localparam logic [6:0] CHAR_NINE   = 7'h39;
  localparam logic [3:0] IDX_HEADER  = 4'h0;
  localparam logic [3:0] IDX_SIGN    = 4'h1;
  localparam logic [3:0] IDX_ROT_LO  = 4'h2;
  localparam logic [3:0] IDX_ROT_HI  = 4'h6;
  localparam logic [3:0] IDX_SHORT_CR = 4'h7;
  localparam logic [3:0] IDX_DOT     = 4'h7;
  localparam logic [3:0] IDX_INIT_LO = 4'h8;
  localparam logic [3:0] IDX_INIT_HI = 4'hD;
  localparam logic [3:0] IDX_LONG_CR = 4'hE;
  localparam logic [16:0] ROT_MAX    = 17'h0FFFF;
  localparam logic [3:0] BIT_START   = 4'h0;
  localparam logic [3:0] BIT_PARITY  = 4'h8;
  localparam logic [3:0] BIT_STOP    = 4'h9;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_RECV  = 4'b0010,
    ST_LOAD  = 4'b0100,
    ST_COUNT = 4'b1000
  } state_t;

  typedef struct packed {
    logic        absolute;
    logic        long_frame;
    logic        circular;
    logic        ccw_positive;
    logic [15:0] pulses_per_rev;
    logic [31:0] circular_max;
  } cfg_t;

  typedef struct packed {
    state_t      fsm;
    logic        a_s1;
    logic        a_s2;
    logic        a_prev;
    logic        b_s1;
    logic        b_s2;
    logic        b_prev;
    logic        rx_busy;
    logic [TIMER_W-1:0] rx_timer;
    logic [3:0]  rx_bit;
    logic [7:0]  rx_shift;
    logic [3:0]  char_idx;
    logic        neg;
    logic [16:0] rot;
    logic [19:0] init;
    logic [31:0] pv;
    logic        request;
    logic        ready;
    logic        err;
  } core_t;

endpackage : abs_rx_pkg

// File: src/abs_encoder_rx.sv
// Absolute encoder data receiver with quadrature position counter
`timescale 1ns/1ns
module abs_encoder_rx #(
  parameter int BIT_CYCLES = abs_rx_pkg::BIT_CYCLES
)
(
  input  wire logic             clk_in,        // 100 MHz clock
  input  wire logic             sys_rst_in,    // Async reset, active high
  input  wire abs_rx_pkg::cfg_t config_in,     // Static counter configuration
  input  wire logic             start_in,      // One-cycle start of operation
  input  wire logic             phase_a_in,    // Encoder phase A pin
  input  wire logic             phase_b_in,    // Encoder phase B pin
  output logic                  absolute_data_request_out, // Request to amplifier
  output logic                  receiving_out, // Frame reception in progress
  output logic                  counting_out,  // Quadrature counting active
  output logic                  position_valid_out, // Absolute position known
  output logic                  frame_error_out,    // Sticky frame fault
  output logic [31:0]           present_value_out   // Signed present value
);

  // ----------------------------------------------------------------
  // Derived timing
  // ----------------------------------------------------------------
  localparam logic [abs_rx_pkg::TIMER_W-1:0] BIT_LAST =
    abs_rx_pkg::TIMER_W'(BIT_CYCLES - 1);
  localparam logic [abs_rx_pkg::TIMER_W-1:0] HALF_LAST =
    abs_rx_pkg::TIMER_W'(BIT_CYCLES / 2 - 1);

  abs_rx_pkg::core_t st_reg;
  abs_rx_pkg::core_t st_next;

  logic        moved;
  logic        step_up;
  logic [6:0]  ch;
  logic        parity_ok;
  logic        is_digit;
  logic [3:0]  digit;
  logic        char_bad;
  logic        frame_end;
  logic [32:0] product;
  logic [31:0] magnitude;
  logic [31:0] preload;
  logic [3:0]  cr_idx;

  // ----------------------------------------------------------------
  // Quadrature decode on synchronised phases
  // ----------------------------------------------------------------
  always_comb
  begin
    moved   = (st_reg.a_s2 ^ st_reg.a_prev) ^ (st_reg.b_s2 ^ st_reg.b_prev);
    step_up = (st_reg.a_s2 ^ st_reg.b_prev) ^ config_in.ccw_positive;
  end

  // ----------------------------------------------------------------
  // Character classification
  // ----------------------------------------------------------------
  always_comb
  begin
    ch        = st_reg.rx_shift[6:0];
    parity_ok = ~(^st_reg.rx_shift);
    is_digit  = (ch >= abs_rx_pkg::CHAR_ZERO) && (ch <= abs_rx_pkg::CHAR_NINE);
    digit     = 4'(ch - abs_rx_pkg::CHAR_ZERO);
    cr_idx    = config_in.long_frame ? abs_rx_pkg::IDX_LONG_CR
                                     : abs_rx_pkg::IDX_SHORT_CR;
    frame_end = (st_reg.char_idx == cr_idx) && (ch == abs_rx_pkg::CHAR_CR);
    char_bad  = 1'b0;
    if ((st_reg.char_idx == abs_rx_pkg::IDX_SIGN)
        && (ch != abs_rx_pkg::CHAR_PLUS) && (ch != abs_rx_pkg::CHAR_MINUS))
    begin
      char_bad = 1'b1;
    end
    else if ((st_reg.char_idx >= abs_rx_pkg::IDX_ROT_LO)
             && (st_reg.char_idx <= abs_rx_pkg::IDX_ROT_HI) && !is_digit)
    begin
      char_bad = 1'b1;
    end
    else if (config_in.long_frame && (st_reg.char_idx == abs_rx_pkg::IDX_DOT)
             && (ch != abs_rx_pkg::CHAR_DOT))
    begin
      char_bad = 1'b1;
    end
    else if (config_in.long_frame && (st_reg.char_idx >= abs_rx_pkg::IDX_INIT_LO)
             && (st_reg.char_idx <= abs_rx_pkg::IDX_INIT_HI) && !is_digit)
    begin
      char_bad = 1'b1;
    end
    else if ((st_reg.char_idx == cr_idx) && (ch != abs_rx_pkg::CHAR_CR))
    begin
      char_bad = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Binary present value from the decoded frame
  // ----------------------------------------------------------------
  always_comb
  begin
    product   = 33'(st_reg.rot * config_in.pulses_per_rev);
    magnitude = product[31:0];
    if (config_in.circular)
    begin
      preload = 32'(st_reg.init);
    end
    else if (st_reg.neg)
    begin
      preload = 32'(st_reg.init) - magnitude;
    end
    else
    begin
      preload = 32'(st_reg.init) + magnitude;
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_next        = st_reg;
    st_next.a_s1   = phase_a_in;
    st_next.a_s2   = st_reg.a_s1;
    st_next.a_prev = st_reg.a_s2;
    st_next.b_s1   = phase_b_in;
    st_next.b_s2   = st_reg.b_s1;
    st_next.b_prev = st_reg.b_s2;

    case (st_reg.fsm)
      abs_rx_pkg::ST_IDLE:
      begin
        if (start_in)
        begin
          st_next.err   = 1'b0;
          st_next.ready = 1'b0;
          st_next.pv    = '0;
          if (config_in.absolute)
          begin
            st_next.fsm      = abs_rx_pkg::ST_RECV;
            st_next.request  = 1'b1;
            st_next.rx_busy  = 1'b0;
            st_next.char_idx = abs_rx_pkg::IDX_HEADER;
          end
          else
          begin
            st_next.fsm = abs_rx_pkg::ST_COUNT;
          end
        end
      end

      abs_rx_pkg::ST_RECV:
      begin
        // Serial data arrives on phase A only; B is ignored meanwhile
        if (!st_reg.rx_busy)
        begin
          if (!st_reg.a_s2)
          begin
            st_next.rx_busy  = 1'b1;
            st_next.rx_timer = '0;
            st_next.rx_bit   = abs_rx_pkg::BIT_START;
          end
        end
        else if (st_reg.rx_bit == abs_rx_pkg::BIT_START)
        begin
          if (st_reg.rx_timer == HALF_LAST)
          begin
            st_next.rx_timer = '0;
            if (st_reg.a_s2)
            begin
              st_next.rx_busy = 1'b0; // Glitch, not a start bit
            end
            else
            begin
              st_next.rx_bit = st_reg.rx_bit + 4'h1;
            end
          end
          else
          begin
            st_next.rx_timer = st_reg.rx_timer + 1'b1;
          end
        end
        else if (st_reg.rx_timer != BIT_LAST)
        begin
          st_next.rx_timer = st_reg.rx_timer + 1'b1;
        end
        else if (st_reg.rx_bit <= abs_rx_pkg::BIT_PARITY)
        begin
          st_next.rx_timer = '0;
          st_next.rx_shift = {st_reg.a_s2, st_reg.rx_shift[7:1]};
          st_next.rx_bit   = st_reg.rx_bit + 4'h1;
        end
        else
        begin
          // Stop bit sampled: character complete
          st_next.rx_busy = 1'b0;
          if (st_reg.char_idx == abs_rx_pkg::IDX_HEADER)
          begin
            // Anything but the header is skipped while hunting for a frame
            if (st_reg.a_s2 && parity_ok && (ch == abs_rx_pkg::CHAR_HEADER))
            begin
              st_next.char_idx = st_reg.char_idx + 4'h1;
              st_next.rot      = '0;
              st_next.init     = '0;
              st_next.neg      = 1'b0;
            end
          end
          else if (!st_reg.a_s2 || !parity_ok || char_bad)
          begin
            st_next.err      = 1'b1;
            st_next.char_idx = abs_rx_pkg::IDX_HEADER;
          end
          else if (frame_end)
          begin
            if (st_reg.rot > abs_rx_pkg::ROT_MAX)
            begin
              st_next.err      = 1'b1;
              st_next.char_idx = abs_rx_pkg::IDX_HEADER;
            end
            else
            begin
              st_next.fsm     = abs_rx_pkg::ST_LOAD;
              st_next.request = 1'b0;
            end
          end
          else
          begin
            st_next.char_idx = st_reg.char_idx + 4'h1;
            if (st_reg.char_idx == abs_rx_pkg::IDX_SIGN)
            begin
              st_next.neg = (ch == abs_rx_pkg::CHAR_MINUS);
            end
            else if (st_reg.char_idx <= abs_rx_pkg::IDX_ROT_HI)
            begin
              st_next.rot = 17'(st_reg.rot * 17'h0000A + 17'(digit));
            end
            else if (st_reg.char_idx >= abs_rx_pkg::IDX_INIT_LO)
            begin
              st_next.init = 20'(st_reg.init * 20'h0000A + 20'(digit));
            end
          end
        end
      end

      abs_rx_pkg::ST_LOAD:
      begin
        st_next.pv    = preload;
        st_next.ready = 1'b1;
        st_next.fsm   = abs_rx_pkg::ST_COUNT;
      end

      abs_rx_pkg::ST_COUNT:
      begin
        // Short frames leave the initial pulses to arrive here as A/B edges
        if (moved)
        begin
          if (step_up)
          begin
            if (config_in.circular && (st_reg.pv >= config_in.circular_max))
            begin
              st_next.pv = '0;
            end
            else
            begin
              st_next.pv = st_reg.pv + 32'h00000001;
            end
          end
          else if (config_in.circular && (st_reg.pv == 32'h00000000))
          begin
            st_next.pv = config_in.circular_max;
          end
          else
          begin
            st_next.pv = st_reg.pv - 32'h00000001;
          end
        end
        if (start_in)
        begin
          st_next.fsm = abs_rx_pkg::ST_IDLE;
        end
      end

      default:
      begin
        st_next.fsm = abs_rx_pkg::ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      st_reg          <= '0;
      st_reg.fsm      <= abs_rx_pkg::ST_IDLE;
      st_reg.a_s1     <= 1'b1;
      st_reg.a_s2     <= 1'b1;
      st_reg.a_prev   <= 1'b1;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all taken from the state register
  // ----------------------------------------------------------------
  always_comb
  begin
    absolute_data_request_out = st_reg.request;
    receiving_out             = st_reg.fsm[1];
    counting_out              = st_reg.fsm[3];
    position_valid_out        = st_reg.ready;
    frame_error_out           = st_reg.err;
    present_value_out         = st_reg.pv;
  end

endmodule : abs_encoder_rx

// File: test/abs_rx_sva.sv
// Port assertions for the absolute encoder data receiver
`timescale 1ns/1ns
module abs_rx_sva #(
  parameter int BIT_CYCLES = 16
)
(
  input wire logic             clk_in,                    // Clock
  input wire logic             sys_rst_in,                // Reset
  input wire abs_rx_pkg::cfg_t config_in,                 // Configuration
  input wire logic             start_in,                  // Start pulse
  input wire logic             phase_a_in,                // Phase A
  input wire logic             phase_b_in,                // Phase B
  input wire logic             absolute_data_request_out, // Request
  input wire logic             receiving_out,             // Receiving
  input wire logic             counting_out,              // Counting
  input wire logic             position_valid_out,        // Valid
  input wire logic             frame_error_out,           // Frame fault
  input wire logic [31:0]      present_value_out          // Present value
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  wire logic idle_w = !absolute_data_request_out && !receiving_out && !counting_out;

  AST_REQ_START:
  assert property (start_in && config_in.absolute && idle_w && !$past(absolute_data_request_out)
    |=> absolute_data_request_out && !position_valid_out) else $error("no request after start");
  AST_INC_START:
  assert property (start_in && !config_in.absolute && idle_w && !$past(absolute_data_request_out)
    |=> counting_out && present_value_out == 32'h0) else $error("incremental start wrong");
  AST_REQ_PAIR:
  assert property (absolute_data_request_out == receiving_out) else $error("request mismatch");
  AST_LOAD:
  assert property ($fell(receiving_out) |-> ##[1:2] (position_valid_out && counting_out))
    else $error("no preload after frame");
  AST_ERR_STICKY:
  assert property (frame_error_out && !start_in |=> frame_error_out) else $error("error lost");
  AST_ERR_REQ:
  assert property ($rose(frame_error_out) |-> absolute_data_request_out && !position_valid_out)
    else $error("request dropped on bad frame");
  AST_STEP:
  assert property (counting_out && $past(counting_out) && !config_in.circular
    |-> (present_value_out - $past(present_value_out)) inside {32'h0, 32'h1, 32'hFFFFFFFF})
    else $error("count jumped");
  AST_STILL:
  assert property ((counting_out && $stable(phase_a_in) && $stable(phase_b_in))[*5]
    |-> $stable(present_value_out)) else $error("count moved without edge");
endmodule : abs_rx_sva

// File: test/amp_model.sv
// Behavioural servo amplifier: absolute frame on A, then quadrature steps
`timescale 1ns/1ns
module amp_model #(
  parameter int BIT_CYCLES = 16
)
(
  input  wire logic clk_in,      // Clock
  input  wire logic request_in,  // Absolute data request
  output logic      phase_a_out, // Serial data, then phase A
  output logic      phase_b_out  // Phase B
);
  initial
  begin
    phase_a_out = 1'b1;
    phase_b_out = 1'b0;
  end

  // Start bit first, data LSB first, even parity, stop
  task automatic send_frame(input string s);
    logic [6:0] c;
    while (request_in !== 1'b1)
      @(posedge clk_in);
    for (int i = 0; i < s.len(); i++)
    begin
      c = 7'(s.getc(i));
      for (int k = 0; k < 10; k++)
      begin
        phase_a_out <= (k == 0) ? 1'b0 : (k < 8) ? c[k-1] : (k == 8) ? ^c : 1'b1;
        repeat (BIT_CYCLES) @(posedge clk_in);
      end
    end
  endtask : send_frame

  // Up means A leads B
  task automatic step(input logic up);
    logic [1:0] n;
    case ({phase_a_out, phase_b_out})
      2'b00: n = up ? 2'b10 : 2'b01;
      2'b10: n = up ? 2'b11 : 2'b00;
      2'b11: n = up ? 2'b01 : 2'b10;
      default: n = up ? 2'b00 : 2'b11;
    endcase
    {phase_a_out, phase_b_out} <= n;
    repeat (6) @(posedge clk_in);
  endtask : step

  // A low in reception would pass for a start bit
  task automatic park;
    phase_a_out <= 1'b1;
    phase_b_out <= 1'b0;
    repeat (4) @(posedge clk_in);
  endtask : park
endmodule : amp_model

// File: test/tb_absolute_encoder_data_receiver.sv
// Self-checking bench for the absolute encoder data receiver
`timescale 1ns/1ns
module tb_absolute_encoder_data_receiver;
  localparam int BIT_CYCLES = 16;
  logic             clk_in = 1'b0;
  logic             sys_rst_in = 1'b1;
  logic             start_in = 1'b0;
  abs_rx_pkg::cfg_t cfg = '0;
  wire logic        pha;
  wire logic        phb;
  logic             req;
  logic             recv;
  logic             cnt;
  logic             valid;
  logic             ferr;
  logic [31:0]      pv;
  int               n_fail = 0;
  int               check_count = 0;

  always #5 clk_in = ~clk_in;

  abs_encoder_rx #(.BIT_CYCLES(BIT_CYCLES)) dut_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .config_in(cfg), .start_in(start_in), .phase_a_in(pha), .phase_b_in(phb),
    .absolute_data_request_out(req), .receiving_out(recv), .counting_out(cnt),
    .position_valid_out(valid), .frame_error_out(ferr), .present_value_out(pv));
  amp_model #(.BIT_CYCLES(BIT_CYCLES)) amp_u (.clk_in(clk_in), .request_in(req),
    .phase_a_out(pha), .phase_b_out(phb));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  function automatic abs_rx_pkg::cfg_t mk(input logic ab, lf, ci, ccw, input logic [15:0] ppr);
    mk = {ab, lf, ci, ccw, ppr, 32'h000003E7};
  endfunction : mk

  task automatic pulse;
    start_in <= 1'b1;
    @(posedge clk_in);
    start_in <= 1'b0;
    repeat (2) @(posedge clk_in);
  endtask : pulse

  // Config only changes while idle
  task automatic begin_op(input abs_rx_pkg::cfg_t c);
    if (cnt === 1'b1)
      pulse();
    amp_u.park();
    cfg <= c;
    @(posedge clk_in);
    pulse();
  endtask : begin_op

  task automatic frame(input string s, input logic [31:0] exp);
    amp_u.send_frame(s);
    for (int n = 0; n < 40 && valid !== 1'b1; n++)
      @(posedge clk_in);
    chk("valid", 32'h1, {31'h0, valid});
    chk("present value", exp, pv);
  endtask : frame

  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_short;
    begin_op(mk(1'b1, 1'b0, 1'b0, 1'b0, 16'h0100));
    chk("request", 32'h1, {31'h0, req});
    chk("receiving", 32'h1, {31'h0, recv});
    frame("P+00003\015", 32'h00000300);
    chk("request off", 32'h0, {31'h0, req});
    chk("receiving off", 32'h0, {31'h0, recv});
    chk("counting", 32'h1, {31'h0, cnt});
    amp_u.step(1'b1);
    amp_u.step(1'b1);
    chk("count up", 32'h00000302, pv);
    $display("test short frame done");
  endtask : t_short

  task automatic t_long;
    begin_op(mk(1'b1, 1'b1, 1'b0, 1'b0, 16'h0100));
    frame("P-00002.000005\015", 32'hFFFFFE05);
    chk("error", 32'h0, {31'h0, ferr});
    $display("test long frame done");
  endtask : t_long

  task automatic t_circ;
    begin_op(mk(1'b1, 1'b1, 1'b1, 1'b1, 16'h0100));
    frame("P+00009.000007\015", 32'h00000007);
    amp_u.step(1'b1);
    chk("reversed count", 32'h00000006, pv);
    $display("test circular done");
  endtask : t_circ

  task automatic t_error;
    begin_op(mk(1'b1, 1'b0, 1'b0, 1'b0, 16'h0001));
    amp_u.send_frame("XP+70000\015");
    repeat (2) @(posedge clk_in);
    chk("error set", 32'h1, {31'h0, ferr});
    chk("request kept", 32'h1, {31'h0, req});
    frame("P+65535\015", 32'h0000FFFF);
    chk("error sticky", 32'h1, {31'h0, ferr});
    $display("test range and error done");
  endtask : t_error

  task automatic t_incr;
    begin_op(mk(1'b0, 1'b0, 1'b0, 1'b0, 16'h0100));
    chk("counting", 32'h1, {31'h0, cnt});
    amp_u.step(1'b1);
    chk("incremental count", 32'h00000001, pv);
    chk("no valid", 32'h0, {31'h0, valid});
    $display("test incremental done");
  endtask : t_incr

  initial
  begin
    repeat (20) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    t_short();
    t_long();
    t_circ();
    t_error();
    t_incr();
    end_sim();
  end

  // Whole run needs roughly 9000 cycles
  initial
  begin
    repeat (40000) @(posedge clk_in);
    n_fail++;
    end_sim();
  end
endmodule : tb_absolute_encoder_data_receiver

bind abs_encoder_rx abs_rx_sva #(.BIT_CYCLES(BIT_CYCLES)) sva_u (.clk_in(clk_in),
  .sys_rst_in(sys_rst_in), .config_in(config_in), .start_in(start_in),
  .phase_a_in(phase_a_in), .phase_b_in(phase_b_in),
  .absolute_data_request_out(absolute_data_request_out), .receiving_out(receiving_out),
  .counting_out(counting_out), .position_valid_out(position_valid_out),
  .frame_error_out(frame_error_out), .present_value_out(present_value_out));
